// file: hw/ssr_pkg.sv
// ssr_pkg: constants for the status reporting block
// assumes: single clock domain, no register bus; selectors come from the command parser
package ssr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int OPW = 16;
   localparam int STW = 8;

   ////////////////////////////////////////////////////////////////////////////
   // register selectors for read and write access
   localparam logic [3:0] SEL_OPERATION_GROUP_COND = 4'h0;
   localparam logic [3:0] SEL_OPERATION_GROUP_EVT  = 4'h1;
   localparam logic [3:0] SEL_OPERATION_GROUP_ENB  = 4'h2;
   localparam logic [3:0] SEL_QUESTIONABLE_GROUP_COND = 4'h3;
   localparam logic [3:0] SEL_QUESTIONABLE_GROUP_EVT  = 4'h4;
   localparam logic [3:0] SEL_QUESTIONABLE_GROUP_ENB  = 4'h5;
   localparam logic [3:0] SEL_STD_COND  = 4'h6;
   localparam logic [3:0] SEL_STD_EVT   = 4'h7;
   localparam logic [3:0] SEL_STD_ENB   = 4'h8;
   localparam logic [3:0] SEL_SRQ_ENB   = 4'h9;
   localparam logic [3:0] SEL_STB       = 4'hA;

   ////////////////////////////////////////////////////////////////////////////
   // operation group bit positions
   localparam int OP_WTG     = 5;
   localparam int OP_ARMED   = 6;
   localparam int OP_CV      = 8;
   localparam int OP_TR_DONE = 9;
   localparam int OP_CC      = 10;
   localparam int OP_SMPL    = 11;
   localparam int OP_LS_DONE = 12;
   localparam int OP_LS_RUN  = 14;
   // bits 9 and 12 travel only through the event path
   localparam logic [15:0] OPERATION_GROUP_COND_RD_MASK = 16'h4D60;

   ////////////////////////////////////////////////////////////////////////////
   // questionable group bit positions
   localparam int QS_CUR_MODE = 0;
   localparam int QS_VLT_MODE = 1;
   localparam int QS_THERM    = 3;
   localparam int QS_SLAVE    = 6;
   localparam int QS_VPROT    = 12;
   localparam int QS_IPROT    = 13;
   localparam int QS_SINK     = 14;
   localparam logic [15:0] QUESTIONABLE_GROUP_USED_MASK = 16'h704B;

   ////////////////////////////////////////////////////////////////////////////
   // status byte bit positions and reset values
   localparam int SB_ERRQ = 3;
   localparam int SB_MAV  = 4;
   localparam int SB_ESB  = 5;
   localparam int SB_RQS  = 6;
   localparam int SB_OPERATION_GROUP = 7;
   localparam logic [7:0]  SB_RQS_MASK = 8'hBF;
   localparam logic [15:0] ENB_RST     = 16'h0000;
   localparam logic [7:0]  STB_RST     = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // instrument status pins, synchronised as one group
   typedef struct packed {
      logic trig_enabled;
      logic ext_trig_src;
      logic trig_in;
      logic transient_armed;
      logic cv_mode;
      logic transient_done;
      logic cc_mode;
      logic sample_done;
      logic list_done;
      logic list_running;
      logic current_mode;
      logic voltage_mode;
      logic thermal_err;
      logic slave_fault;
      logic vprot_err;
      logic iprot_err;
      logic ext_ref;
      logic sinking;
   } ssr_pins_t;

endpackage : ssr_pkg

// file: hw/ssr_event_group.sv
// ssr_event_group: condition edge detect, event latch and enable mask
// assumes: cond_i is synchronous to clk_i; ce_i low freezes all state
`timescale 1ns/1ps
module ssr_event_group #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         arst_n_i,
   input  wire logic         ce_i,
   // condition and access
   input  wire logic [W-1:0] cond_i,
   input  wire logic         en_wr_i,
   input  wire logic [W-1:0] en_data_i,
   input  wire logic         evt_clr_i,
   // results
   output logic      [W-1:0] evt_o,
   output logic      [W-1:0] en_o,
   output logic              sum_o
);

   logic [W-1:0] prev_r;
   logic [W-1:0] evt_r;
   logic [W-1:0] en_r;
   logic [W-1:0] rise;

   assign rise  = cond_i & ~prev_r;
   assign evt_o = evt_r;
   assign en_o  = en_r;
   assign sum_o = |(evt_r & en_r);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev_r <= '0;
      end else if (ce_i) begin
         prev_r <= cond_i;
      end
   end

   // new rising edge wins over a clearing read
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         evt_r <= '0;
      end else if (ce_i) begin
         evt_r <= (evt_clr_i ? '0 : evt_r) | rise;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         en_r <= '0;
      end else if (ce_i && en_wr_i) begin
         en_r <= en_data_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   evt_latch_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      ce_i && (rise != '0) |=> ((evt_o & $past(rise)) == $past(rise)))
      else $error("rising condition not latched");
   evt_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      ce_i && !evt_clr_i && (rise == '0) |=> evt_o == $past(evt_o))
      else $error("event changed without a rising condition");
   evt_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      ce_i && evt_clr_i && (rise == '0) |=> evt_o == '0)
      else $error("event register not cleared by read");

endmodule : ssr_event_group

// file: hw/ssr_status_top.sv
// ssr_status_top: instrument status reporting, groups, status byte and service request
// assumes: status pins are asynchronous; parser strobes, std_cond_i and queue flags share clk_i
//
// Functional notes
// - status byte bit 3 stays zero while no error is queued and no enabled questionable event is latched.
// - status byte bit 4 set while a query answer waits in output buffer.
// - operation and questionable are 16 bits; standard event and request 8.
// - each condition register has an event register and an enable mask.
// - event bit latches only on a zero to one condition transition.
// - reading an event register returns it, then clears all its bits except those rising in that cycle.
// - enabled questionable event sets questionable summary at status byte bit 3.
// - request byte ANDed with enable except bit 6; OR goes to bit 6.
// - service request line active whenever status byte bit 6 is one.
// - status byte bit 3 set while error and event queue is nonempty.
// - operation condition bits 0 to 4, 7, 13, 15 read zero.
// - operation bit 5 trigger enabled; external low trigger holds it until high.
// - operation bits 6, 8, 10, 11, 14 flag armed, CV, CC, sample, list.
// - operation bits 9 and 12 are event-only, unreadable in condition.
// - questionable bit 0 current mode, bit 1 voltage mode.
// - questionable bit 3 thermal error, bit 6 slave fault.
// - questionable bit 12 voltage protect, 13 current protect, 14 sinking.
// - protection error under external reference sets both bits 12 and 13.
// - questionable bits 2, 4, 5, 7 to 11, 15 read zero.
`timescale 1ns/1ps
module ssr_status_top (
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   arst_n_i,
   input  wire logic                   ce_i,
   // trigger and operating state pins
   input  wire logic                   trig_enabled_i,
   input  wire logic                   ext_trig_src_i,
   input  wire logic                   trig_in_i,
   input  wire logic                   transient_armed_i,
   input  wire logic                   cv_mode_i,
   input  wire logic                   transient_done_i,
   input  wire logic                   cc_mode_i,
   input  wire logic                   sample_done_i,
   input  wire logic                   list_done_i,
   input  wire logic                   list_running_i,
   // fault and mode pins
   input  wire logic                   current_mode_i,
   input  wire logic                   voltage_mode_i,
   input  wire logic                   thermal_err_i,
   input  wire logic                   slave_fault_i,
   input  wire logic                   vprot_err_i,
   input  wire logic                   iprot_err_i,
   input  wire logic                   ext_ref_i,
   input  wire logic                   sinking_i,
   // parser side conditions
   input  wire logic [ssr_pkg::STW-1:0] std_cond_i,
   input  wire logic                   err_queue_nonempty_i,
   input  wire logic                   out_msg_avail_i,
   // register access
   input  wire logic                   rd_en_i,
   input  wire logic [3:0]             rd_sel_i,
   input  wire logic                   wr_en_i,
   input  wire logic [3:0]             wr_sel_i,
   input  wire logic [ssr_pkg::OPW-1:0] wr_data_i,
   input  wire logic                   spoll_i,
   // results
   output logic      [ssr_pkg::OPW-1:0] rd_data_o,
   output logic      [ssr_pkg::STW-1:0] spoll_data_o,
   output logic                        srq_o
);
   import ssr_pkg::*;

   function automatic logic sel_hit(input logic en, input logic [3:0] sel, input logic [3:0] code);
      sel_hit = en && (sel == code);
   endfunction : sel_hit

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser
   ssr_pins_t pins_raw;
   ssr_pins_t pins_meta_r;
   ssr_pins_t pins_sync_r;

   assign pins_raw = '{trig_enabled: trig_enabled_i, ext_trig_src: ext_trig_src_i,
                       trig_in: trig_in_i, transient_armed: transient_armed_i,
                       cv_mode: cv_mode_i, transient_done: transient_done_i,
                       cc_mode: cc_mode_i, sample_done: sample_done_i,
                       list_done: list_done_i, list_running: list_running_i,
                       current_mode: current_mode_i, voltage_mode: voltage_mode_i,
                       thermal_err: thermal_err_i, slave_fault: slave_fault_i,
                       vprot_err: vprot_err_i, iprot_err: iprot_err_i,
                       ext_ref: ext_ref_i, sinking: sinking_i};

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pins_meta_r <= '0;
         pins_sync_r <= '0;
      end else if (ce_i) begin
         pins_meta_r <= pins_raw;
         pins_sync_r <= pins_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trigger wait hold
   logic wait_hold_r;
   logic trigger_wait_flag;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wait_hold_r <= 1'b0;
      end else if (ce_i) begin
         if (pins_sync_r.trig_in) begin
            wait_hold_r <= 1'b0;
         end else if (pins_sync_r.trig_enabled && pins_sync_r.ext_trig_src) begin
            wait_hold_r <= 1'b1;
         end
      end
   end

   assign trigger_wait_flag = pins_sync_r.trig_enabled | wait_hold_r;

   ////////////////////////////////////////////////////////////////////////////
   // condition registers
   logic [OPW-1:0] operation_condition;
   logic [OPW-1:0] questionable_condition;
   logic           prot_both;

   assign prot_both = pins_sync_r.ext_ref && (pins_sync_r.vprot_err || pins_sync_r.iprot_err);

   always_comb begin
      operation_condition             = '0;
      operation_condition[OP_WTG]     = trigger_wait_flag;
      operation_condition[OP_ARMED]   = pins_sync_r.transient_armed;
      operation_condition[OP_CV]      = pins_sync_r.cv_mode;
      operation_condition[OP_TR_DONE] = pins_sync_r.transient_done;
      operation_condition[OP_CC]      = pins_sync_r.cc_mode;
      operation_condition[OP_SMPL]    = pins_sync_r.sample_done;
      operation_condition[OP_LS_DONE] = pins_sync_r.list_done;
      operation_condition[OP_LS_RUN]  = pins_sync_r.list_running;
   end

   always_comb begin
      questionable_condition              = '0;
      questionable_condition[QS_CUR_MODE] = pins_sync_r.current_mode;
      questionable_condition[QS_VLT_MODE] = pins_sync_r.voltage_mode;
      questionable_condition[QS_THERM]    = pins_sync_r.thermal_err;
      questionable_condition[QS_SLAVE]    = pins_sync_r.slave_fault;
      questionable_condition[QS_VPROT]    = pins_sync_r.vprot_err | prot_both;
      questionable_condition[QS_IPROT]    = pins_sync_r.iprot_err | prot_both;
      questionable_condition[QS_SINK]     = pins_sync_r.sinking;
   end

   ////////////////////////////////////////////////////////////////////////////
   // event groups
   logic [OPW-1:0] operation_group_evt;
   logic [OPW-1:0] operation_group_en;
   logic [OPW-1:0] questionable_group_evt;
   logic [OPW-1:0] questionable_mask_reg;
   logic [STW-1:0] std_evt;
   logic [STW-1:0] std_en;
   logic           operation_group_sum;
   logic           questionable_group_sum;
   logic           std_sum;

   ssr_event_group #(.W(OPW)) u_operation_group (
      .clk_i     (clk_i),
      .arst_n_i  (arst_n_i),
      .ce_i      (ce_i),
      .cond_i    (operation_condition),
      .en_wr_i   (sel_hit(wr_en_i, wr_sel_i, SEL_OPERATION_GROUP_ENB)),
      .en_data_i (wr_data_i),
      .evt_clr_i (sel_hit(rd_en_i, rd_sel_i, SEL_OPERATION_GROUP_EVT)),
      .evt_o     (operation_group_evt),
      .en_o      (operation_group_en),
      .sum_o     (operation_group_sum)
   );

   ssr_event_group #(.W(OPW)) u_questionable_group (
      .clk_i     (clk_i),
      .arst_n_i  (arst_n_i),
      .ce_i      (ce_i),
      .cond_i    (questionable_condition),
      .en_wr_i   (sel_hit(wr_en_i, wr_sel_i, SEL_QUESTIONABLE_GROUP_ENB)),
      .en_data_i (wr_data_i),
      .evt_clr_i (sel_hit(rd_en_i, rd_sel_i, SEL_QUESTIONABLE_GROUP_EVT)),
      .evt_o     (questionable_group_evt),
      .en_o      (questionable_mask_reg),
      .sum_o     (questionable_group_sum)
   );

   ssr_event_group #(.W(STW)) u_std_group (
      .clk_i     (clk_i),
      .arst_n_i  (arst_n_i),
      .ce_i      (ce_i),
      .cond_i    (std_cond_i),
      .en_wr_i   (sel_hit(wr_en_i, wr_sel_i, SEL_STD_ENB)),
      .en_data_i (wr_data_i[STW-1:0]),
      .evt_clr_i (sel_hit(rd_en_i, rd_sel_i, SEL_STD_EVT)),
      .evt_o     (std_evt),
      .en_o      (std_en),
      .sum_o     (std_sum)
   );

   ////////////////////////////////////////////////////////////////////////////
   // status byte and service request
   logic [STW-1:0] srq_en_r;
   logic [STW-1:0] sb_base;
   logic [STW-1:0] sb_nxt;
   logic [STW-1:0] sb_r;
   logic           srq_r;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         srq_en_r <= ENB_RST[STW-1:0];
      end else if (ce_i && sel_hit(wr_en_i, wr_sel_i, SEL_SRQ_ENB)) begin
         srq_en_r <= wr_data_i[STW-1:0] & SB_RQS_MASK;
      end
   end

   always_comb begin
      sb_base          = '0;
      sb_base[SB_ERRQ] = err_queue_nonempty_i | questionable_group_sum;
      sb_base[SB_MAV]  = out_msg_avail_i;
      sb_base[SB_ESB]  = std_sum;
      sb_base[SB_OPERATION_GROUP] = operation_group_sum;
      sb_nxt           = sb_base;
      sb_nxt[SB_RQS]   = |(sb_base & srq_en_r & SB_RQS_MASK);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sb_r  <= STB_RST;
         srq_r <= 1'b0;
      end else if (ce_i) begin
         sb_r  <= sb_nxt;
         srq_r <= sb_nxt[SB_RQS];
      end
   end

   assign srq_o = srq_r;

   ////////////////////////////////////////////////////////////////////////////
   // read port and serial poll
   logic [OPW-1:0] rd_data_r;
   logic [STW-1:0] spoll_r;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_data_r <= '0;
      end else if (ce_i && rd_en_i) begin
         unique case (rd_sel_i)
            SEL_OPERATION_GROUP_COND: rd_data_r <= operation_condition & OPERATION_GROUP_COND_RD_MASK;
            SEL_OPERATION_GROUP_EVT:  rd_data_r <= operation_group_evt;
            SEL_OPERATION_GROUP_ENB:  rd_data_r <= operation_group_en;
            SEL_QUESTIONABLE_GROUP_COND: rd_data_r <= questionable_condition & QUESTIONABLE_GROUP_USED_MASK;
            SEL_QUESTIONABLE_GROUP_EVT:  rd_data_r <= questionable_group_evt;
            SEL_QUESTIONABLE_GROUP_ENB:  rd_data_r <= questionable_mask_reg;
            SEL_STD_COND:  rd_data_r <= {8'h00, std_cond_i};
            SEL_STD_EVT:   rd_data_r <= {8'h00, std_evt};
            SEL_STD_ENB:   rd_data_r <= {8'h00, std_en};
            SEL_SRQ_ENB:   rd_data_r <= {8'h00, srq_en_r};
            SEL_STB:       rd_data_r <= {8'h00, sb_r};
            default:       rd_data_r <= '0;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         spoll_r <= STB_RST;
      end else if (ce_i && spoll_i) begin
         spoll_r <= sb_r;
      end
   end

   assign rd_data_o    = rd_data_r;
   assign spoll_data_o = spoll_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   stb_no_error_a: assert property (ce_i && !err_queue_nonempty_i && !questionable_group_sum |=> !sb_r[SB_ERRQ])
      else $error("bit 3 set with no queued error");
   stb_mav_a: assert property (ce_i && out_msg_avail_i |=> sb_r[SB_MAV])
      else $error("message available not shown in bit 4");
   stb_questionable_group_a: assert property (ce_i && questionable_group_sum |=> sb_r[SB_ERRQ])
      else $error("questionable summary missing");
   stb_errq_a: assert property (ce_i && err_queue_nonempty_i |=> sb_r[SB_ERRQ])
      else $error("error queue not reported");
   rqs_summary_a: assert property (ce_i |=> sb_r[SB_RQS] == |(sb_r & $past(srq_en_r) & SB_RQS_MASK))
      else $error("request summary wrong");
   srq_line_a: assert property (srq_o == sb_r[SB_RQS])
      else $error("service request line disagrees with bit 6");
   operation_group_unused_a: assert property (ce_i && rd_en_i && rd_sel_i == SEL_OPERATION_GROUP_COND |=> (rd_data_o & ~OPERATION_GROUP_COND_RD_MASK) == '0)
      else $error("unused or event-only operation bit read as one");
   questionable_group_unused_a: assert property (ce_i && rd_en_i && rd_sel_i == SEL_QUESTIONABLE_GROUP_COND |=> (rd_data_o & ~QUESTIONABLE_GROUP_USED_MASK) == '0)
      else $error("unused questionable bit read as one");
   wtg_hold_a: assert property (ce_i && wait_hold_r && !pins_sync_r.trig_in ##1 !pins_sync_r.trig_in |-> operation_condition[OP_WTG])
      else $error("trigger wait flag dropped while input low");
   prot_pair_a: assert property (prot_both |-> questionable_condition[QS_IPROT:QS_VPROT] == 2'b11)
      else $error("protection bits not set together");
   operation_group_sum_a: assert property (ce_i && operation_group_sum |=> sb_r[SB_OPERATION_GROUP])
      else $error("operation summary missing");

   srq_rise_c: cover property (ce_i && !srq_o ##1 srq_o);
   questionable_group_clear_c: cover property (ce_i && questionable_group_evt != '0 && sel_hit(rd_en_i, rd_sel_i, SEL_QUESTIONABLE_GROUP_EVT) ##1 questionable_group_evt == '0);
   wtg_hold_c: cover property (wait_hold_r && !pins_sync_r.trig_enabled);
   prot_pair_c: cover property (prot_both && !pins_sync_r.iprot_err);

endmodule : ssr_status_top

// file: verification/ssr_host_model.sv
// ssr_host_model: host side that issues reads, enable writes and serial polls
// assumes: strobes change at the falling edge, block samples on the rising edge
`timescale 1ns/1ps
module ssr_host_model (
   // clock
   input  wire logic        clk_i,
   // access strobes
   output logic             rd_en_o,
   output logic [3:0]       rd_sel_o,
   output logic             wr_en_o,
   output logic [3:0]       wr_sel_o,
   output logic [15:0]      wr_data_o,
   output logic             spoll_o
);
   initial begin
      {rd_en_o, wr_en_o, spoll_o} = 3'h0;
      {rd_sel_o, wr_sel_o, wr_data_o} = 24'h0;
   end

   // one request held across one rising edge, then released
   task acc(input logic r, input logic w, input logic p, input logic [3:0] s, input logic [15:0] d);
      @(negedge clk_i);
      {rd_en_o, wr_en_o, spoll_o} = {r, w, p};
      {rd_sel_o, wr_sel_o, wr_data_o} = {s, s, d};
      @(negedge clk_i);
      {rd_en_o, wr_en_o, spoll_o} = 3'h0;
      // released data lines show no stale value
      {rd_sel_o, wr_sel_o, wr_data_o} = ~{s, s, d};
   endtask : acc
endmodule : ssr_host_model

// file: verification/test_scpi_status_reporting.sv
// test_scpi_status_reporting: self-checking bench for ssr_status_top
// assumes: ssr_host_model drives access strobes; pins are driven here
`timescale 1ns/1ps
module test_scpi_status_reporting;
   import ssr_pkg::*;
   logic        clk_i, arst_n_i, errq, mav, rd_d, sp_d, srq, ce;
   logic [17:0] pv;
   logic [7:0]  std_c, sb;
   logic [15:0] rd_data;
   wire         rd_en, wr_en, sp;
   wire  [3:0]  rs, ws;
   wire  [15:0] wd;
   logic [15:0] q_rd[$];
   logic [7:0]  q_sb[$];
   int          n_fail, samples_checked;

   ssr_host_model i_host (.clk_i(clk_i), .rd_en_o(rd_en), .rd_sel_o(rs), .wr_en_o(wr_en),
      .wr_sel_o(ws), .wr_data_o(wd), .spoll_o(sp));
   ssr_status_top i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce),
      .trig_enabled_i(pv[17]), .ext_trig_src_i(pv[16]), .trig_in_i(pv[15]), .transient_armed_i(pv[14]),
      .cv_mode_i(pv[13]), .transient_done_i(pv[12]), .cc_mode_i(pv[11]), .sample_done_i(pv[10]),
      .list_done_i(pv[9]), .list_running_i(pv[8]), .current_mode_i(pv[7]), .voltage_mode_i(pv[6]),
      .thermal_err_i(pv[5]), .slave_fault_i(pv[4]), .vprot_err_i(pv[3]), .iprot_err_i(pv[2]),
      .ext_ref_i(pv[1]), .sinking_i(pv[0]), .std_cond_i(std_c), .err_queue_nonempty_i(errq),
      .out_msg_avail_i(mav), .rd_en_i(rd_en), .rd_sel_i(rs), .wr_en_i(wr_en), .wr_sel_i(ws),
      .wr_data_i(wd), .spoll_i(sp), .rd_data_o(rd_data), .spoll_data_o(sb), .srq_o(srq));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] op_x(logic [17:0] v);
      return {1'b0, v[8], 2'b00, v[10], v[11], 1'b0, v[13], 1'b0, v[14], v[17], 5'h00};
   endfunction : op_x
   function automatic logic [15:0] qs_x(logic [17:0] v);
      return {1'b0, v[0], v[2] | (v[1] & v[3]), v[3] | (v[1] & v[2]), 5'h00, v[4], 2'b00, v[5], 1'b0, v[6], v[7]};
   endfunction : qs_x

   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task rdc(input logic [3:0] s, input logic [15:0] e);
      q_rd.push_back(e);
      i_host.acc(1'b1, 1'b0, 1'b0, s, 16'h0000);
   endtask : rdc
   task wr(input logic [3:0] s, input logic [15:0] d);
      i_host.acc(1'b0, 1'b1, 1'b0, s, d);
   endtask : wr
   task poll(input logic [7:0] e);
      q_sb.push_back(e);
      i_host.acc(1'b0, 1'b0, 1'b1, 4'h0, 16'h0000);
   endtask : poll
   task settle();
      repeat (6) @(negedge clk_i);
   endtask : settle
   task final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////////
   // result monitor: answers stand from the taking edge and are checked at the falling edge after it
   always @(posedge clk_i) begin
      rd_d <= rd_en;
      sp_d <= sp;
   end
   always @(negedge clk_i) begin
      if (rd_d === 1'b1) chk("rd_data", q_rd.pop_front(), rd_data);
      if (sp_d === 1'b1) chk("status", {8'h00, q_sb.pop_front()}, {8'h00, sb});
   end

   initial begin
      #200000;
      n_fail++;
      final_report();
   end

   initial begin
      {pv, std_c, errq, mav, arst_n_i} = 29'h0;
      ce = 1'b1;
      n_fail = 0;
      samples_checked = 0;
      void'($urandom(32'h70dc26d0));
      repeat (10) @(negedge clk_i);
      arst_n_i = 1'b1;
      rdc(SEL_OPERATION_GROUP_COND, 16'h0000);
      poll(8'h00);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         pv = 18'($urandom);
         pv[16] = 1'b0;
         std_c = 8'($urandom);
         settle();
         rdc(SEL_OPERATION_GROUP_COND, op_x(pv));
         rdc(SEL_QUESTIONABLE_GROUP_COND, qs_x(pv));
      end
      $display("test condition map done");
      {pv, std_c} = 26'h0;
      settle();
      arst_n_i = 1'b0;
      @(negedge clk_i);
      arst_n_i = 1'b1;
      pv[5] = 1'b1;
      settle();
      rdc(SEL_QUESTIONABLE_GROUP_EVT, 16'h0008);
      rdc(SEL_QUESTIONABLE_GROUP_EVT, 16'h0000);
      wr(SEL_QUESTIONABLE_GROUP_ENB, 16'h0008);
      wr(SEL_OPERATION_GROUP_ENB, 16'h0100);
      wr(SEL_SRQ_ENB, 16'h0048);
      rdc(SEL_SRQ_ENB, 16'h0008);
      poll(8'h00);
      pv[5] = 1'b0;
      settle();
      {pv[5], pv[13]} = 2'b11;
      settle();
      poll(8'hC8);
      chk("srq", 16'h0001, {15'h0000, srq});
      rdc(SEL_OPERATION_GROUP_EVT, 16'h0100);
      rdc(SEL_QUESTIONABLE_GROUP_EVT, 16'h0008);
      {errq, mav} = 2'b11;
      settle();
      poll(8'h58);
      chk("srq", 16'h0001, {15'h0000, srq});
      $display("test summary done");
      {errq, mav} = 2'b00;
      pv[17:15] = 3'b110;
      settle();
      pv[17] = 1'b0;
      settle();
      rdc(SEL_OPERATION_GROUP_COND, 16'h0120);
      pv[15] = 1'b1;
      settle();
      rdc(SEL_OPERATION_GROUP_COND, 16'h0100);
      wr(SEL_STD_ENB, 16'h0001);
      std_c = 8'h01;
      settle();
      poll(8'h20);
      chk("srq", 16'h0000, {15'h0000, srq});
      $display("test trigger and standard done");
      rdc(SEL_STB, 16'h0020);
      ce = 1'b0;
      rdc(SEL_STD_EVT, 16'h0020);
      ce = 1'b1;
      rdc(SEL_STD_EVT, 16'h0001);
      rdc(SEL_STD_COND, 16'h0001);
      rdc(SEL_STD_ENB, 16'h0001);
      rdc(SEL_QUESTIONABLE_GROUP_ENB, 16'h0008);
      rdc(SEL_OPERATION_GROUP_ENB, 16'h0100);
      rdc(4'hB, 16'h0000);
      $display("test freeze and readback done");
      settle();
      final_report();
   end
endmodule : test_scpi_status_reporting
